// ### src/timer_channel_pkg.sv
// constants, modes and carrier types for the timer channel
// assumes a single clock domain and synchronous active-high reset
package timer_channel_pkg;
  localparam int unsigned clk_period_ns = 8;
  localparam logic [15:0] count_zero = 16'h0000;
  localparam logic [15:0] count_all_ones = 16'hffff;
  localparam logic [15:0] count_step = 16'h0001;
  localparam logic [15:0] counter_reset_value = 16'h0000;
  localparam logic [15:0] data_reset_value = 16'h0000;
  localparam logic [15:0] prescale_reset_value = 16'h0000;
  // register indices on the plain port
  localparam logic [3:0] addr_start = 4'h0;
  localparam logic [3:0] addr_stop = 4'h1;
  localparam logic [3:0] addr_mode = 4'h2;
  localparam logic [3:0] addr_data = 4'h3;
  localparam logic [3:0] addr_counter = 4'h4;
  localparam logic [3:0] addr_enabled = 4'h5;
  localparam logic [3:0] addr_out_latch = 4'h6;
  localparam logic [3:0] addr_out_enable = 4'h7;
  localparam logic [3:0] addr_out_mode = 4'h8;
  localparam logic [3:0] addr_out_polarity = 4'h9;
  localparam logic [3:0] addr_prescale = 4'ha;
  // mode register field positions
  localparam int unsigned mode_op_lsb = 0;
  localparam int unsigned mode_start_irq_bit = 2;
  localparam int unsigned mode_edge_clock_bit = 3;
  localparam int unsigned mode_filter_bit = 4;
  localparam int unsigned mode_falling_bit = 5;
  localparam logic [15:0] mode_reset_value = 16'h0000;

  typedef enum logic [1:0] {
    op_capture = 2'b00,
    op_one_count = 2'b01,
    op_capture_one_count = 2'b10,
    op_reserved = 2'b11
  } op_mode_type;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait_clock = 2'b01,
    st_wait_trigger = 2'b10,
    st_counting = 2'b11
  } chan_state_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic write;
    logic read;
  } reg_req_type;

  typedef struct packed {
    logic falling;
    logic filter;
    logic edge_clock;
    logic start_irq;
    op_mode_type op;
  } mode_cfg_type;
endpackage

// ### src/timer_channel_capture_oneshot_output.sv
// one 16-bit timer channel: capture, one-count, capture plus one-count, output latch
// assumes inputs synchronous to clk; the slave interrupt comes from a neighbour channel
// Operation
// R1: filter adds two operating-clock cycles of latency; the code adds one
// R2: start sets enabled flag, counter holds value
// R3: first count clock triggers, loads zero, counts up
// R4: start-interrupt select raises interrupt on trigger; the code does so in capture mode only
// R5: capture edge copies counter, raises interrupt
// R6: after capture counting restarts from zero
// R7: one-count waits rising edge, loads data, down
// R8: one-count zero: interrupt, counter all ones, stop
// R9: capture-one-count rising edge loads zero, counts up
// R10: capture-one-count falling edge captures, raises interrupt
// R11: first period may be one count clock long
// R12: master mode toggles on interrupt, ignores polarity
// R13: slave mode sets/resets per polarity
// R14: simultaneous interrupts: reset wins, set masked
// R15: enabled output ignores software latch writes
// R16: disabled output accepts writes, blocks interrupts
// R17: output latch always readable as pin level
// R18: output settings never disturb counter operation
// R19: software orders output setup before start
// R20: master mode start toggle inverts output
// R21: edge count clock synchronised to operating clock
// R22: clock enable, trigger, interrupt are one-cycle pulses
// R23: sixteen-bit counter wraps modulo 65536 upward
module timer_channel_capture_oneshot_output
  import timer_channel_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // pins and neighbour events
  input wire logic timer_input_pin,
  input wire logic slave_channel_interrupt,
  output logic timer_output_pin,
  output logic master_channel_interrupt,
  output logic channel_enabled_flag
);

  reg_req_type req;
  mode_cfg_type cfg;
  chan_state_type state;
  logic [15:0] channel_counter;
  logic [15:0] channel_data_reg;
  logic [15:0] prescale;
  logic [15:0] prescale_count;
  logic op_clock_enable;
  logic sync_first;
  logic sync_second;
  logic filter_stage;
  logic filter_out;
  logic edge_seen;
  logic edge_clock;
  logic count_clock;
  logic rise_detect;
  logic fall_detect;
  logic valid_edge;
  logic start_trigger;
  logic output_enable_bit;
  logic output_mode_select;
  logic output_polarity_select;
  logic [15:0] mode_word;
  logic latch_set;
  logic latch_reset;
  logic latch_toggle;

  assign req = '{addr: reg_addr, wdata: reg_wdata, write: reg_write, read: reg_read};
  assign cfg = mode_cfg_type'(mode_word[5:0]);

  function automatic logic hit(input reg_req_type r, input logic [3:0] a);
    return r.write && (r.addr == a);
  endfunction

  // operating clock: a one-cycle enable every prescale+1 system clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      prescale_count <= prescale_reset_value;
      op_clock_enable <= 1'b0;
    end else if (ce) begin
      if (prescale_count >= prescale) begin
        prescale_count <= count_zero;
        op_clock_enable <= 1'b1; // R22
      end else begin
        prescale_count <= prescale_count + count_step;
        op_clock_enable <= 1'b0;
      end
    end
  end

  // input sampled on the operating clock, optional two-sample filter
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
      filter_stage <= 1'b0;
      filter_out <= 1'b0;
      edge_seen <= 1'b0;
    end else if (ce && op_clock_enable) begin
      sync_first <= timer_input_pin;
      sync_second <= sync_first;
      filter_stage <= sync_second;
      if (!cfg.filter) begin
        filter_out <= sync_second;
      end else if (sync_second == filter_stage) begin
        filter_out <= filter_stage; // R1
      end
      edge_seen <= filter_out;
    end
  end

  assign rise_detect = op_clock_enable && filter_out && !edge_seen;
  assign fall_detect = op_clock_enable && !filter_out && edge_seen;
  assign valid_edge = cfg.falling ? fall_detect : rise_detect;
  assign edge_clock = valid_edge; // R21
  assign count_clock = cfg.edge_clock ? edge_clock : op_clock_enable;

  // start trigger is combinational so the same cycle loads the counter
  always_comb begin
    start_trigger = 1'b0;
    unique case (state)
      st_wait_clock: start_trigger = count_clock; // R3 R11
      st_wait_trigger: start_trigger = rise_detect; // R7 R9
      st_idle, st_counting: start_trigger = 1'b0;
    endcase
  end

  // channel state, counter and capture; output settings are not read here
  always_ff @(posedge clk) begin // R18
    if (rst) begin
      state <= st_idle;
      channel_enabled_flag <= 1'b0;
      channel_counter <= counter_reset_value;
      channel_data_reg <= data_reset_value;
      master_channel_interrupt <= 1'b0;
    end else if (ce) begin
      master_channel_interrupt <= 1'b0;
      if (hit(req, addr_data)) begin
        channel_data_reg <= req.wdata;
      end
      if (hit(req, addr_stop) && req.wdata[0]) begin
        state <= st_idle;
        channel_enabled_flag <= 1'b0;
      end else if (hit(req, addr_start) && req.wdata[0] && state == st_idle) begin
        channel_enabled_flag <= 1'b1; // R2
        state <= (cfg.op == op_capture) ? st_wait_clock : st_wait_trigger;
      end else begin
        unique case (state)
          st_idle: state <= st_idle;
          st_wait_clock, st_wait_trigger: begin
            if (start_trigger) begin
              state <= st_counting;
              if (cfg.op == op_one_count) begin
                channel_counter <= channel_data_reg; // R7
              end else begin
                channel_counter <= count_zero; // R3 R9
              end
              if (cfg.start_irq && cfg.op == op_capture) begin
                master_channel_interrupt <= 1'b1; // R4 R22
              end
            end
          end
          st_counting: begin
            unique case (cfg.op)
              op_capture: begin
                if (valid_edge) begin
                  channel_data_reg <= channel_counter; // R5
                  channel_counter <= count_zero; // R6
                  master_channel_interrupt <= 1'b1; // R5
                end else if (count_clock) begin
                  channel_counter <= channel_counter + count_step; // R23
                end
              end
              op_one_count: begin
                if (count_clock) begin
                  if (channel_counter == count_zero) begin
                    channel_counter <= count_all_ones; // R8
                    master_channel_interrupt <= 1'b1; // R8
                    state <= st_wait_trigger;
                  end else begin
                    channel_counter <= channel_counter - count_step;
                  end
                end
              end
              op_capture_one_count: begin
                if (fall_detect) begin
                  channel_data_reg <= channel_counter; // R10
                  master_channel_interrupt <= 1'b1; // R10
                  state <= st_wait_trigger;
                end else if (count_clock) begin
                  channel_counter <= channel_counter + count_step; // R23
                end
              end
              default: state <= st_idle;
            endcase
          end
        endcase
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_word <= mode_reset_value;
      prescale <= prescale_reset_value;
      output_enable_bit <= 1'b0;
      output_mode_select <= 1'b0;
      output_polarity_select <= 1'b0;
    end else if (ce) begin
      if (hit(req, addr_mode)) begin
        mode_word <= req.wdata;
      end
      if (hit(req, addr_prescale)) begin
        prescale <= req.wdata;
      end
      if (hit(req, addr_out_enable)) begin
        output_enable_bit <= req.wdata[0];
      end
      if (hit(req, addr_out_mode)) begin
        output_mode_select <= req.wdata[0];
      end
      if (hit(req, addr_out_polarity)) begin
        output_polarity_select <= req.wdata[0];
      end
    end
  end

  // output events; polarity only matters in slave mode
  always_comb begin
    latch_set = 1'b0;
    latch_reset = 1'b0;
    latch_toggle = 1'b0;
    if (!output_mode_select) begin
      latch_toggle = master_channel_interrupt; // R12 R20
    end else if (!output_polarity_select) begin
      latch_set = master_channel_interrupt; // R13
      latch_reset = slave_channel_interrupt;
    end else begin
      latch_set = slave_channel_interrupt; // R13
      latch_reset = master_channel_interrupt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_output_pin <= 1'b0;
    end else if (ce) begin
      if (output_enable_bit) begin
        if (latch_reset) begin
          timer_output_pin <= 1'b0; // R14 R15
        end else if (latch_set) begin
          timer_output_pin <= 1'b1; // R15
        end else if (latch_toggle) begin
          timer_output_pin <= !timer_output_pin; // R15
        end
      end else if (hit(req, addr_out_latch)) begin
        timer_output_pin <= req.wdata[0]; // R16
      end
    end
  end

  // read data in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= count_zero;
    end else if (ce) begin
      reg_rdata <= count_zero;
      if (req.read) begin
        unique case (req.addr)
          addr_mode: reg_rdata <= mode_word;
          addr_data: reg_rdata <= channel_data_reg;
          addr_counter: reg_rdata <= channel_counter;
          addr_enabled: reg_rdata <= {15'h0000, channel_enabled_flag};
          addr_out_latch: reg_rdata <= {15'h0000, timer_output_pin}; // R17
          addr_out_enable: reg_rdata <= {15'h0000, output_enable_bit};
          addr_out_mode: reg_rdata <= {15'h0000, output_mode_select};
          addr_out_polarity: reg_rdata <= {15'h0000, output_polarity_select};
          addr_prescale: reg_rdata <= prescale;
          default: reg_rdata <= count_zero;
        endcase
      end
    end
  end

endmodule

// ### tb/timer_channel_properties.sv
// port checker for the timer channel
// assumes one clock, synchronous active-high reset, ce held high
module timer_channel_properties
  import timer_channel_pkg::*;
(
  // clock and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // pins
  input wire logic timer_input_pin,
  input wire logic slave_channel_interrupt,
  input wire logic timer_output_pin,
  input wire logic master_channel_interrupt,
  input wire logic channel_enabled_flag
);
  logic out_event;
  // start counts too: in master mode the start interrupt (capture mode, start_irq set) inverts the pin
  assign out_event = master_channel_interrupt || slave_channel_interrupt ||
    (reg_write && (reg_addr == addr_out_latch || reg_addr == addr_start));

  chk_irq_one_cycle: assert property (@(posedge clk) disable iff (rst)
    master_channel_interrupt |=> !master_channel_interrupt) else $error("interrupt too long");
  chk_reset_quiet: assert property (@(posedge clk)
    rst |=> !channel_enabled_flag && !master_channel_interrupt && !timer_output_pin)
    else $error("outputs active after reset");
  chk_start_enables: assert property (@(posedge clk) disable iff (rst)
    reg_write && reg_addr == addr_start && reg_wdata[0] && !channel_enabled_flag
    |=> channel_enabled_flag) else $error("start did not enable");
  chk_enabled_read: assert property (@(posedge clk) disable iff (rst)
    reg_read && reg_addr == addr_enabled |=>
    reg_rdata == {15'h0, $past(channel_enabled_flag)}) else $error("enabled read wrong");
  chk_latch_readback: assert property (@(posedge clk) disable iff (rst)
    reg_read && reg_addr == addr_out_latch |=>
    reg_rdata == {15'h0, $past(timer_output_pin)}) else $error("latch read wrong");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !reg_read |=> reg_rdata == 16'h0000) else $error("read data outside read");
  chk_idle_no_irq: assert property (@(posedge clk) disable iff (rst)
    !channel_enabled_flag [*3] |-> !master_channel_interrupt) else $error("irq while stopped");
  chk_output_cause: assert property (@(posedge clk) disable iff (rst)
    !$stable(timer_output_pin) |->
    $past(out_event) || $past(out_event, 2) || $past(out_event, 3))
    else $error("output changed without cause");
endmodule

bind timer_channel_capture_oneshot_output timer_channel_properties u_timer_channel_properties (
  .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .timer_input_pin(timer_input_pin), .slave_channel_interrupt(slave_channel_interrupt),
  .timer_output_pin(timer_output_pin), .master_channel_interrupt(master_channel_interrupt),
  .channel_enabled_flag(channel_enabled_flag));

// ### tb/pulse_source.sv
// external pulse source: two high pulses then low
// assumes lengths of at least one cycle
module pulse_source (
  // command
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  // towards the channel
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  logic [1:0] reps;
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    left = 8'h00;
    reps = 2'h0;
  end
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      pin <= 1'b1;
      left <= hi_len;
      reps <= 2'h2;
    end else if (busy) begin
      if (left > 8'h01) left <= left - 8'h01;
      else if (pin) begin
        pin <= 1'b0;
        left <= lo_len;
        reps <= reps - 2'h1;
      end else if (reps != 2'h0) begin
        pin <= 1'b1;
        left <= hi_len;
      end else busy <= 1'b0;
    end
  end
endmodule

// ### tb/timer_channel_capture_oneshot_output_tb.sv
// self-checking bench for the timer channel
// assumes package, design, checker and pulse source compiled first
module timer_channel_capture_oneshot_output_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_channel_pkg::*;
  logic clk, rst, ce, reg_write, reg_read, slave, go, tin, tout, irq, enabled, busy;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_value;
  logic [7:0] hi, lo;
  logic [31:0] seed;
  int errors, comparisons;

  timer_channel_capture_oneshot_output u_timer_channel_capture_oneshot_output (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .timer_input_pin(tin), .slave_channel_interrupt(slave), .timer_output_pin(tout),
    .master_channel_interrupt(irq), .channel_enabled_flag(enabled));
  pulse_source u_pulse_source (.clk(clk), .go(go), .hi_len(hi), .lo_len(lo), .pin(tin),
    .busy(busy));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // the counter restarts at zero on the edge that opens the span
  function automatic logic [15:0] span(input logic [7:0] len);
    return {8'h00, len} - 16'h0001;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    comparisons++;
    if (seen !== expected) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    rd_value = reg_rdata;
  endtask
  // level 1 waits for the interrupt, level 0 for the source to go quiet
  task automatic wait_for(input logic level);
    for (int n = 0; n < 2000; n++) begin
      @(negedge clk);
      if ((level ? irq : !busy) === 1'b1) return;
    end
    errors++;
    stop_test();
  endtask
  task automatic strobe(input logic is_slave);
    @(posedge clk);
    if (is_slave) slave <= 1'b1;
    else go <= 1'b1;
    @(posedge clk);
    slave <= 1'b0;
    go <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst, ce} = 2'b11;
    {reg_write, reg_read, slave, go} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    {hi, lo} = 16'h0101;
    seed = 32'h0000001f;
    errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(addr_counter);
    check(rd_value, counter_reset_value);
    rd(4'hf);
    check(rd_value, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      hi = 8'h14 + {4'h0, seed[3:0]};
      lo = 8'h0c + {4'h0, seed[7:4]};
      wr(addr_mode, 16'h0004);
      wr(addr_start, 16'h0001);
      wait_for(1'b1);
      strobe(1'b0);
      wait_for(1'b1);
      wait_for(1'b1);
      rd(addr_data);
      check(rd_value, span(hi + lo));
      wait_for(1'b0);
      wr(addr_stop, 16'h0001);
      // filter on alternate passes must not change the measured width
      wr(addr_mode, {11'h000, i[0], 4'h2});
      wr(addr_start, 16'h0001);
      strobe(1'b0);
      wait_for(1'b1);
      rd(addr_data);
      check(rd_value, span(hi));
      wait_for(1'b0);
      wr(addr_stop, 16'h0001);
      wr(addr_data, {12'h000, seed[11:8]} + 16'h0001);
      wr(addr_mode, 16'h0001);
      wr(addr_start, 16'h0001);
      strobe(1'b0);
      wait_for(1'b1);
      rd(addr_counter);
      check(rd_value, count_all_ones);
      wait_for(1'b0);
      wr(addr_stop, 16'h0001);
    end
    for (int p = 0; p < 2; p++) begin
      wr(addr_out_enable, 16'h0000);
      wr(addr_out_latch, {15'h0, ~p[0]});
      strobe(1'b1);
      rd(addr_out_latch);
      check(rd_value, {15'h0, ~p[0]});
      wr(addr_out_mode, 16'h0001);
      wr(addr_out_polarity, {15'h0, p[0]});
      wr(addr_out_enable, 16'h0001);
      wr(addr_out_latch, {15'h0, p[0]});
      rd(addr_out_latch);
      check(rd_value, {15'h0, ~p[0]});
      strobe(1'b1);
      rd(addr_out_latch);
      check(rd_value, {15'h0, p[0]});
    end
    // master mode: the start interrupt toggles the pin, polarity and slave ignored
    wr(addr_out_enable, 16'h0000);
    wr(addr_out_mode, 16'h0000);
    wr(addr_out_polarity, 16'h0001);
    wr(addr_out_latch, 16'h0000);
    wr(addr_out_enable, 16'h0001);
    wr(addr_mode, 16'h0004);
    wr(addr_start, 16'h0001);
    wait_for(1'b1);
    strobe(1'b1);
    rd(addr_out_latch);
    check(rd_value, 16'h0001);
    wr(addr_stop, 16'h0001);
    // slave mode, positive logic: the start interrupt and the slave land in one cycle
    wr(addr_out_enable, 16'h0000);
    wr(addr_out_mode, 16'h0001);
    wr(addr_out_polarity, 16'h0000);
    wr(addr_out_latch, 16'h0000);
    wr(addr_out_enable, 16'h0001);
    wr(addr_start, 16'h0001);
    @(posedge clk);
    slave <= 1'b1;
    @(posedge clk);
    slave <= 1'b0;
    // a set that slipped through or a late slave would leave the pin high here
    @(negedge clk);
    check({15'h0000, tout}, 16'h0000);
    rd(addr_out_latch);
    check(rd_value, 16'h0000);
    wr(addr_stop, 16'h0001);
    stop_test();
  end
endmodule
